// ==== disk_pack_exception_status_bench.sv ====
// self-checking bench for the exception and result logic
`timescale 1ns/10ps
`default_nettype none
module disk_pack_exception_status_bench
  import dpes_pkg::*;
;
  logic clk_in = 0, rst_n_in = 0, op_start_in = 0, ecc_return_in = 0, wait_busy_in = 1;
  logic op_end_in = 0, init_phase_in = 0, unit_ready_in = 1, unit_safe_in = 1;
  logic unit_present_in = 1, spindle_missing_in = 0, unit_busy_in = 0, unit_seeking_in = 0;
  logic seek_ff_set_in = 0, seek_ff_other_cyl_in = 0, write_lockout_in = 0, slip_in = 0;
  logic ecc_mismatch_in = 0, drive_fail_in = 0, first_sector_in = 0, addr_par_err_in = 0;
  logic cyl_head_ok_in = 1, sector_not_found_in = 0, large_drive_in = 0;
  logic sector_pulse_miss_in = 0, read_data_miss_in = 0, clock_pulse_in = 1;
  logic seek_timeout_in = 0, ctrl_msg_sent_in = 0, ctrl_msg_error_in = 0;
  logic [1:0]  test_wait_select_in = 2'h0, config_in = 2'h0, ext_valid_code_in = 2'h0;
  logic [2:0]  unit_id_in = 3'h0;
  logic [23:0] drive_control_message_in = 24'h00_0000, drive_status_in = 24'h00_0000;
  logic [20:0] ext_detail_in = 21'h00_0000;
  dpes_op_t    op_code_in = OP_READ;
  wire         link_valid_in, link_is_result_in, link_par_in;
  wire  [DRV_W-1:0] link_word_in;
  logic        op_active_out, result_valid_out;
  logic [RB_W-1:0]  result_out;
  logic [EX_W-1:0]  extended_fault_report_out;
  int          n_mismatch = 0, checks = 0;

  dpes_top #(.TMO_CYC(50)) uut (.*);
  dpes_link_model link (.clk_in(clk_in), .link_valid_out(link_valid_in),
    .link_is_result_out(link_is_result_in), .link_word_out(link_word_in),
    .link_par_out(link_par_in));

  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic start(input dpes_op_t op, input logic ecc, input logic [1:0] wsel);
    @(posedge clk_in);
    #1;
    op_start_in = 1'b1;
    op_code_in = op;
    ecc_return_in = ecc;
    test_wait_select_in = wsel;
    @(posedge clk_in);
    #1;
    op_start_in = 1'b0;
  endtask
  // waits for the result pulse; op_end is raised at cycle n unless the op ended itself
  task automatic fin(input string nm, input int n);
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clk_in);
      #1;
      if (result_valid_out === 1'b1)
        break;
      op_end_in = (i == n);
    end
    op_end_in = 1'b0;
    if (i == 300)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      stop_test();
    end
    $display("done %s", nm);
  endtask
  ////////////////////////////////////////
  task automatic t_not_ready();
    unit_ready_in = 1'b0;
    start(OP_READ, 1'b0, 2'h0);
    fin("not ready", 999);
    chk(result_out, 24'h01_0007);
    unit_ready_in = 1'b1;
  endtask
  task automatic t_absent();
    unit_present_in = 1'b0;
    start(OP_WRITE, 1'b0, 2'h0);
    fin("absent", 999);
    chk(result_out, 24'h01_0007);
    start(OP_TEST, 1'b0, WSEL_PRESENT);
    fin("test absent", 999);
    chk(result_out[RB_DONE2], 1'b0);
    chk(result_out[RB_NRDY], 1'b0);
    unit_present_in = 1'b1;
  endtask
  task automatic t_test_ready();
    start(OP_TEST, 1'b0, WSEL_ABSENT);
    fin("test ready", 999);
    chk(result_out[RB_DONE2], 1'b0);
  endtask
  task automatic t_lockout();
    write_lockout_in = 1'b1;
    start(OP_WRITE, 1'b0, 2'h0);
    fin("lockout", 999);
    chk(result_out, 24'h01_0043);
    write_lockout_in = 1'b0;
  endtask
  // reset in the middle of a running operation clears the active flag and the result
  task automatic t_reset();
    start(OP_READ, 1'b0, 2'h0);
    rst_n_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk(op_active_out, 1'b0);
    chk(result_out, 24'h00_0000);
    rst_n_in = 1'b1;
    $display("done mid-run reset");
  endtask
  task automatic t_slip();
    slip_in = 1'b1;
    start(OP_WRITE, 1'b0, 2'h0);
    fin("slip", 3);
    chk(result_out, 24'h01_0081);
    slip_in = 1'b0;
  endtask
  task automatic t_code_return();
    ecc_mismatch_in = 1'b1;
    start(OP_READ, 1'b1, 2'h0);
    fin("code return", 3);
    chk(result_out, 24'h80_0001);
    start(OP_READ, 1'b0, 2'h0);
    fin("read check", 3);
    chk(result_out, 24'h01_000B);
    ecc_mismatch_in = 1'b0;
  endtask
  task automatic t_timeout();
    clock_pulse_in = 1'b0;
    start(OP_READ, 1'b0, 2'h0);
    chk(op_active_out, 1'b1);
    fin("timeout", 999);
    chk(result_out, 24'h01_0803);
    chk(op_active_out, 1'b0);
    clock_pulse_in = 1'b1;
  endtask
  task automatic t_parity();
    start(OP_WRITE, 1'b0, 2'h0);
    link.send(16'h0000, 1'b0, 1'b1);
    fin("parity", 3);
    chk(result_out, 24'h01_8003);
    init_phase_in = 1'b1;
    start(OP_WRITE, 1'b0, 2'h0);
    link.send(16'h0000, 1'b0, 1'b1);
    fin("initiate parity", 999);
    chk(result_out, 24'h01_8003);
    init_phase_in = 1'b0;
    start(OP_READ, 1'b0, 2'h0);
    link.send(16'h8000, 1'b1, 1'b1);
    fin("result parity", 3);
    chk(result_out, 24'h01_8003);
  endtask
  task automatic t_drive_map();
    ctrl_msg_error_in = 1'b1;
    drive_control_message_in = 24'h12_3456;
    ctrl_msg_sent_in = 1'b1;
    start(OP_READ, 1'b0, 2'h0);
    ctrl_msg_sent_in = 1'b0;
    link.send(16'h8000, 1'b1, 1'b0);
    fin("drive map", 3);
    chk(result_out, 24'hC0_0013);
    chk(extended_fault_report_out[15:0], 16'h8000);
    chk(extended_fault_report_out[61:37], {24'h12_3456, 1'b1});
    ctrl_msg_error_in = 1'b0;
  endtask
  task automatic t_missing();
    large_drive_in = 1'b1;
    sector_pulse_miss_in = 1'b1;
    start(OP_READ, 1'b0, 2'h0);
    fin("sector pulses", 999);
    chk(result_out, 24'hC0_0E13);
    sector_pulse_miss_in = 1'b0;
    read_data_miss_in = 1'b1;
    start(OP_READ, 1'b0, 2'h0);
    fin("read data", 3);
    chk(result_out, 24'h01_0E03);
    read_data_miss_in = 1'b0;
    large_drive_in = 1'b0;
  endtask
  task automatic t_address();
    first_sector_in = 1'b1;
    addr_par_err_in = 1'b1;
    start(OP_WRITE, 1'b0, 2'h0);
    fin("address parity", 999);
    chk(result_out, 24'h01_0203);
    addr_par_err_in = 1'b0;
    sector_not_found_in = 1'b1;
    start(OP_READ, 1'b0, 2'h0);
    fin("sector address", 999);
    chk(result_out, 24'h01_0403);
    sector_not_found_in = 1'b0;
    first_sector_in = 1'b0;
  endtask
  task automatic t_no_store();
    start(OP_PAUSE, 1'b0, 2'h0);
    fin("pause", 3);
    chk(result_out[RB_DONE2], 1'b0);
    drive_status_in = 24'h65_4321;
    ext_valid_code_in = 2'h3;
    unit_busy_in = 1'b1;
    wait_busy_in = 1'b0;
    start(OP_WRITE, 1'b0, 2'h0);
    fin("busy", 3);
    chk(result_out[RB_DONE2], 1'b0);
    chk(extended_fault_report_out[63:37], {2'h3, 24'h65_4321, 1'b0});
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_not_ready();
    t_absent();
    t_test_ready();
    t_lockout();
    t_reset();
    t_slip();
    t_code_return();
    t_timeout();
    t_parity();
    t_drive_map();
    t_missing();
    t_address();
    t_no_store();
    stop_test();
  end
endmodule // disk_pack_exception_status_bench
`default_nettype wire

// ==== dpes_link_model.sv ====
// drive electronics link model: sends status and result words to the control
`timescale 1ns/10ps
`default_nettype none
module dpes_link_model
  import dpes_pkg::*;
(
  input  wire logic             clk_in,
  output logic                  link_valid_out,
  output logic                  link_is_result_out,
  output logic [DRV_W-1:0]      link_word_out,
  output logic                  link_par_out
);
  initial
  begin
    link_valid_out = 1'b0;
    link_is_result_out = 1'b0;
    link_word_out = 16'h0000;
    link_par_out = 1'b0;
  end
  ////////////////////////////////////////
  // one word per call; bad flips parity so the word arrives with even parity
  task automatic send(input logic [DRV_W-1:0] w, input logic res, input logic bad);
    @(posedge clk_in);
    #1;
    link_valid_out = 1'b1;
    link_is_result_out = res;
    link_word_out = w;
    link_par_out = ~(^w) ^ bad;
    @(posedge clk_in);
    #1;
    link_valid_out = 1'b0;
    // released word lines must not keep showing the last value
    link_word_out = ~w;
    link_par_out = ^w;
  endtask
endmodule // dpes_link_model
`default_nettype wire

// ==== dpes_par_chk.sv ====
// odd parity checker for one link word
`timescale 1ns/10ps
`default_nettype none
module dpes_par_chk
  import dpes_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic [W-1:0] word_in,
  input  wire logic         par_in,
  output logic              even_err_out
);
  // even parity over word and parity bit is a transmission error
  assign even_err_out = ~(^{word_in, par_in}); // R13
endmodule // dpes_par_chk
`default_nettype wire

// ==== dpes_pkg.sv ====
// constants and types for the disk pack exception and result logic
// Summary of operation
// R1: drive electronics or drive not ready or unsafe ends the operation with not-ready.
// R2: absent drive gives not-ready on every operation but a test with wait select 10.
// R3: missing spindle on single-spindle drive gives not-ready without not-present.
// R4: read code mismatch gives read data error at completion unless code-return variant.
// R5: sector code detects bursts up to 32 bits, corrects up to 11 in software.
// R6: any drive electronics or drive failure sets result bit 4.
// R7: write lockout ends write, initialize or relocate at once and is flagged.
// R8: slip is informational and never sets the exception summary bit 1.
// R9: address parity or sync error after first wanted sector ends the operation.
// R10: missing sector pulses set 4,9,10,11,22,23; missing read data sets 9,10,11.
// R11: sector not found with correct cylinder, head and no parity error stops at once.
// R12: timeout on 1 second without clock pulse, or on seek timeout.
// R13: link transfers carry odd parity; initiate error ends at once, later at completion.
// R14: after result transmission error only bits 0,1,7,15,16 (test adds 7-11,17-23) valid.
// R15: bit 16 cleared on pause, seeking unit, or seek flip-flop for other cylinder.
// R16: bit 16 cleared for read, write, relocate, initialize to busy unit without wait.
// R17: test wait 10 clears bit 16 if not ready, absent, seeking; wait 01 if ready.
// R18: read with code return gives flags 001, extended status raised gives 011, bit 16 clear.
// R19: a result with transmission parity bit 15 always keeps bit 16 set.
// R20: drive electronics result word forms extended status bits 0 to 15.
// R21: each drive electronics result bit is translated onto its result bit; drive bits 10-13 are not mapped here.
// R22: extended bit 37 selects last control message or drive status in bits 38-61.
// R23: bit 1 summarises bits 2-4,6,9-15,22 on non-test operations.
// R24: deferred conditions are latched and assembled into the result at the end.
package dpes_pkg;
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_INIT, OP_RELOC, OP_TEST, OP_PAUSE} dpes_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} dpes_state_t;
  localparam int RB_DONE   = 0;
  localparam int RB_EXC    = 1;
  localparam int RB_NRDY   = 2;
  localparam int RB_RDERR  = 3;
  localparam int RB_ATTN   = 4;
  localparam int RB_LOCK   = 6;
  localparam int RB_SLIP   = 7;
  localparam int RB_APAR   = 9;
  localparam int RB_SADR   = 10;
  localparam int RB_TMO    = 11;
  localparam int RB_SEEKG  = 12;
  localparam int RB_SEEKFF = 14;
  localparam int RB_XPAR   = 15;
  localparam int RB_DONE2  = 16;
  localparam int RB_ID_LO  = 17;
  localparam int RB_SF_LO  = 21;
  localparam int RB_W      = 24;
  localparam logic [2:0] SF_ECC = 3'h1;
  localparam logic [2:0] SF_EXT = 3'h3;
  localparam logic [1:0] WSEL_PRESENT = 2'h2;
  localparam logic [1:0] WSEL_ABSENT  = 2'h1;
  localparam int DRV_W      = 16;
  localparam int DRV_ABSENT = 9;
  localparam int EX_W       = 64;
  localparam int EX_MSG_ERR = 37;
  localparam int EX_MSG_LO  = 38;
  localparam int EX_MSG_W   = 24;
  localparam int EX_VLD_LO  = 62;
  localparam logic [RB_W-1:0] RES_RESET = 24'h00_0000;
  localparam logic [EX_W-1:0] EXT_RESET = 64'h0000_0000_0000_0000;
  localparam longint CLK_HZ      = 100_000_000;
  localparam longint TIMEOUT_SEC = 1;
  localparam int     TIMEOUT_CYC = int'(TIMEOUT_SEC * CLK_HZ);
  // arbitrary neutral identity value, not any real control code
  localparam logic [6:0] CTRL_ID_DEFAULT = 7'h2A;
endpackage : dpes_pkg

// ==== dpes_top.sv ====
// exception detection and result assembly for the disk pack control
`timescale 1ns/10ps
`default_nettype none
module dpes_top
  import dpes_pkg::*;
#(
  parameter int         TMO_CYC = TIMEOUT_CYC,
  parameter logic [6:0] CTRL_ID = CTRL_ID_DEFAULT
)(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              op_start_in,
  input  var  dpes_op_t          op_code_in,
  input  wire logic              ecc_return_in,
  input  wire logic              wait_busy_in,
  input  wire logic [1:0]        test_wait_select_in,
  input  wire logic              op_end_in,
  input  wire logic              init_phase_in,
  input  wire logic              unit_ready_in,
  input  wire logic              unit_safe_in,
  input  wire logic              unit_present_in,
  input  wire logic              spindle_missing_in,
  input  wire logic              unit_busy_in,
  input  wire logic              unit_seeking_in,
  input  wire logic              seek_ff_set_in,
  input  wire logic              seek_ff_other_cyl_in,
  input  wire logic              write_lockout_in,
  input  wire logic              slip_in,
  input  wire logic              ecc_mismatch_in,
  input  wire logic              drive_fail_in,
  input  wire logic              first_sector_in,
  input  wire logic              addr_par_err_in,
  input  wire logic              cyl_head_ok_in,
  input  wire logic              sector_not_found_in,
  input  wire logic              large_drive_in,
  input  wire logic              sector_pulse_miss_in,
  input  wire logic              read_data_miss_in,
  input  wire logic              clock_pulse_in,
  input  wire logic              seek_timeout_in,
  input  wire logic [2:0]        unit_id_in,
  input  wire logic [1:0]        config_in,
  input  wire logic              link_valid_in,
  input  wire logic              link_is_result_in,
  input  wire logic [DRV_W-1:0]  link_word_in,
  input  wire logic              link_par_in,
  input  wire logic              ctrl_msg_sent_in,
  input  wire logic [23:0]       drive_control_message_in,
  input  wire logic              ctrl_msg_error_in,
  input  wire logic [23:0]       drive_status_in,
  input  wire logic [20:0]       ext_detail_in,
  input  wire logic [1:0]        ext_valid_code_in,
  output logic                   op_active_out,
  output logic                   result_valid_out,
  output logic [RB_W-1:0]        result_out,
  output logic [EX_W-1:0]        extended_fault_report_out
);
  ////////////////////////////////////////////////////////////////////////////////
  dpes_state_t        state_reg, state_next;
  dpes_op_t           op_reg;
  logic               ecc_reg, wait_reg;
  logic [1:0]         wsel_reg;
  logic [RB_W-1:0]    acc_reg, acc_next, ev_bits, drv_map, raw, res_next;
  logic [DRV_W-1:0]   drv_reg;
  logic [23:0]        msg_reg;
  logic [31:0]        tmo_cnt_reg;
  logic               rpar_reg, result_valid_reg, op_active_reg;
  logic [RB_W-1:0]    result_reg;
  logic [EX_W-1:0]    ext_reg, ext_next;
  wire                par_err;
  wire                start      = (state_reg == ST_IDLE) && op_start_in;
  wire                run        = (state_reg == ST_RUN);
  wire                is_test    = (op_reg == OP_TEST);
  wire                is_read    = (op_reg == OP_READ);
  wire                is_pause   = (op_reg == OP_PAUSE);
  wire                rw_rel     = is_read || (op_reg == OP_WRITE) || (op_reg == OP_RELOC);
  wire                wclass     = (op_reg == OP_WRITE) || (op_reg == OP_INIT)
                                   || (op_reg == OP_RELOC);
  wire                rwri       = rw_rel || (op_reg == OP_INIT);
  wire                wsel_pres  = is_test && (wsel_reg == WSEL_PRESENT);
  wire                wsel_abs   = is_test && (wsel_reg == WSEL_ABSENT);
  wire                link_err   = run && link_valid_in && par_err;
  wire                drv_arrive = run && link_valid_in && link_is_result_in;
  wire                absent_nr  = !unit_present_in && !wsel_pres;
  wire                nrdy_ev    = run && (!unit_ready_in || !unit_safe_in
                                   || spindle_missing_in || absent_nr);
  wire                lock_ev    = run && write_lockout_in && wclass;
  wire                apar_ev    = run && addr_par_err_in && first_sector_in;
  wire                spm_ev     = run && sector_pulse_miss_in && large_drive_in;
  wire                rdm_ev     = run && read_data_miss_in;
  wire                sadr_ev    = run && rw_rel && sector_not_found_in && cyl_head_ok_in
                                   && !addr_par_err_in;
  wire                clk_tmo    = run && rw_rel && !clock_pulse_in
                                   && (tmo_cnt_reg == 32'(TMO_CYC - 1));
  wire                tmo_ev     = clk_tmo || (run && rwri && seek_timeout_in);
  wire                term_now   = run && (nrdy_ev || lock_ev || apar_ev || sadr_ev
                                   || tmo_ev || spm_ev || (link_err && init_phase_in)
                                   || op_end_in || is_test);

  dpes_par_chk #(.W(DRV_W)) u_par (
    .word_in      (link_word_in),
    .par_in       (link_par_in),
    .even_err_out (par_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // translation of drive electronics result bits onto result bits
  always_comb
  begin
    drv_map = '0;
    drv_map[RB_RDERR]  = drv_reg[0];                           // R21
    drv_map[RB_LOCK]   = drv_reg[1];
    drv_map[RB_SEEKFF] = drv_reg[2];
    drv_map[RB_SEEKG]  = drv_reg[3];
    drv_map[RB_NRDY]   = drv_reg[4] | drv_reg[5] | drv_reg[DRV_ABSENT];
    drv_map[RB_APAR]   = drv_reg[6];
    drv_map[RB_SADR]   = drv_reg[7];
    drv_map[RB_TMO]    = drv_reg[8];
    drv_map[RB_XPAR]   = drv_reg[14];
    drv_map[RB_ATTN]   = drv_reg[15];                          // R6
    drv_map[22]        = drv_reg[15];
    drv_map[23]        = drv_reg[15];
    // a code-return read hands the raw check back, so no read error is raised
    if (is_read && ecc_reg)
      drv_map[RB_RDERR] = 1'b0;                                // R4
  end

  // events that set deferred flags in result bit positions
  always_comb
  begin
    ev_bits = '0;
    ev_bits[RB_NRDY]   = nrdy_ev;                              // R1 R2 R3
    // the drive's code detects bursts to 32 bits; 11-bit repair is software's job
    ev_bits[RB_RDERR]  = run && is_read && ecc_mismatch_in && !ecc_reg; // R4 R5
    ev_bits[RB_ATTN]   = (run && drive_fail_in) || spm_ev;     // R6 R10
    ev_bits[RB_LOCK]   = lock_ev;                              // R7
    ev_bits[RB_SLIP]   = run && slip_in;                       // R8
    ev_bits[RB_APAR]   = apar_ev || spm_ev || rdm_ev;          // R9 R10
    ev_bits[RB_SADR]   = sadr_ev || spm_ev || rdm_ev;          // R11 R10
    ev_bits[RB_TMO]    = tmo_ev || spm_ev || rdm_ev;           // R12 R10
    ev_bits[RB_XPAR]   = link_err;                             // R13
    ev_bits[22]        = spm_ev;                               // R10
    ev_bits[23]        = spm_ev;                               // R10
  end

  // new events win over the clear at operation start
  assign acc_next = (start ? '0 : acc_reg) | ev_bits;         // R24

  ////////////////////////////////////////////////////////////////////////////////
  // final result assembly, done in the cycle after termination
  wire clr_done2 = is_pause                                    // R15
                   || (rw_rel && (unit_seeking_in || seek_ff_other_cyl_in))
                   || (rwri && unit_busy_in && !wait_reg)      // R16
                   || (wsel_pres && (!unit_ready_in || !unit_present_in
                                     || unit_seeking_in))      // R17
                   || (wsel_abs && unit_ready_in);             // R17
  wire ext_raised = rwri && (|drv_reg);
  wire [2:0] sflag = (is_read && ecc_reg) ? SF_ECC :
                     ext_raised            ? SF_EXT : 3'h0;    // R18
  wire exc_rw = |{raw[4:2], raw[6], raw[15:9], raw[22]};       // R23
  wire exc_t  = |{raw[RB_NRDY], raw[RB_LOCK], raw[RB_SEEKG], raw[RB_SEEKFF], raw[RB_XPAR]};

  always_comb
  begin
    raw = acc_reg | drv_map;                                   // R21
    raw[RB_DONE] = 1'b1;
    raw[RB_EXC]  = 1'b0;
    raw[RB_SEEKFF] = raw[RB_SEEKFF] | (seek_ff_set_in && (rw_rel || is_test));
    if (is_test)
    begin
      raw[RB_SEEKG] = raw[RB_SEEKG] | unit_seeking_in;
      raw[RB_SLIP]  = unit_id_in[2];
      raw[8]        = unit_id_in[1];
      raw[RB_APAR]  = unit_id_in[0];
      raw[RB_SADR]  = config_in[1];
      raw[RB_TMO]   = config_in[0];
      for (int i = 0; i < 7; i++)
        raw[RB_ID_LO + i] = CTRL_ID[6 - i];
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        raw[RB_SF_LO + i] = raw[RB_SF_LO + i] | sflag[2 - i];  // R18
    end
    // any nonzero special flag, own or mapped from the drive, asks for the extended read
    raw[RB_DONE2] = !(clr_done2 || (!is_test && (raw[RB_SF_LO +: 3] != 3'h0))); // R15 R18
  end

  always_comb
  begin
    res_next = raw;
    res_next[RB_EXC] = is_test ? exc_t : exc_rw;               // R23 R8
    if (rpar_reg)
    begin
      // a damaged result word leaves only the control's own bits trustworthy
      res_next = '0;                                           // R14
      res_next[RB_DONE] = 1'b1;
      res_next[RB_EXC]  = 1'b1;
      res_next[RB_SLIP] = raw[RB_SLIP];
      res_next[RB_XPAR] = 1'b1;
      if (is_test)
        res_next[23:17] = raw[23:17];
      if (is_test)
        res_next[11:7] = raw[11:7];
    end
    if (res_next[RB_XPAR])
      res_next[RB_DONE2] = 1'b1;                               // R19
  end

  // extended fault report built from drive result and message history
  always_comb
  begin
    ext_next = '0;
    ext_next[DRV_W-1:0] = drv_reg;                             // R20
    if (spindle_missing_in)
      ext_next[DRV_ABSENT] = 1'b0;                             // R3
    ext_next[36:16] = ext_detail_in;
    ext_next[EX_MSG_ERR] = ctrl_msg_error_in;
    ext_next[EX_MSG_LO +: EX_MSG_W] = ctrl_msg_error_in ? msg_reg : drive_status_in; // R22
    ext_next[EX_VLD_LO +: 2] = ext_valid_code_in;              // R22
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (op_start_in) state_next = ST_RUN;
      ST_RUN:  if (term_now)    state_next = ST_DONE;          // R1 R7 R9 R11 R12 R13
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_READ;
      ecc_reg   <= 1'b0;
      wait_reg  <= 1'b0;
      wsel_reg  <= 2'h0;
      acc_reg   <= RES_RESET;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      if (start)
      begin
        op_reg   <= op_code_in;
        ecc_reg  <= ecc_return_in;
        wait_reg <= wait_busy_in;
        wsel_reg <= test_wait_select_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      drv_reg     <= 16'h0000;
      rpar_reg    <= 1'b0;
      msg_reg     <= 24'h00_0000;
      tmo_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      if (start)
        drv_reg <= 16'h0000;
      else if (drv_arrive)
        drv_reg <= link_word_in;                               // R20
      rpar_reg <= (!start && rpar_reg) || (drv_arrive && par_err); // R13 R14
      if (ctrl_msg_sent_in)
        msg_reg <= drive_control_message_in;
      tmo_cnt_reg <= (!run || clock_pulse_in) ? 32'h0000_0000 : tmo_cnt_reg + 32'h0000_0001; // R12
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      result_reg       <= RES_RESET;
      result_valid_reg <= 1'b0;
      op_active_reg    <= 1'b0;
      ext_reg          <= EXT_RESET;
    end
    else
    begin
      result_valid_reg <= (state_reg == ST_DONE);
      op_active_reg    <= (state_next == ST_RUN);
      if (state_reg == ST_DONE)
      begin
        result_reg <= res_next;                                // R24
        ext_reg    <= ext_next;
      end
    end
  end

  assign op_active_out             = op_active_reg;
  assign result_valid_out          = result_valid_reg;
  assign result_out                = result_reg;
  assign extended_fault_report_out = ext_reg;

  ////////////////////////////////////////////////////////////////////////////////
  chk_nrdy_term: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    nrdy_ev |-> ##2 (result_valid_out && (result_out[RB_NRDY] || result_out[RB_XPAR])))
    else $error("not-ready did not end the operation");
  chk_lock_term: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    lock_ev |=> (state_reg == ST_DONE) ##1 (result_out[RB_LOCK] || result_out[RB_XPAR]))
    else $error("write lockout not terminated or flagged");
  chk_tmo_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    tmo_ev |-> ##2 (result_valid_out && (result_out[RB_TMO] || result_out[RB_XPAR])))
    else $error("timeout not reported");
  chk_slip_only: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    (result_valid_out && result_out[RB_SLIP] && (result_out[15:2] & 14'h3F97) == 14'h0000
     && !result_out[22] && $past(!is_test)) |-> !result_out[RB_EXC])
    else $error("slip alone raised the summary bit");
  chk_xpar_done2: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R19
    (result_valid_out && result_out[RB_XPAR]) |-> result_out[RB_DONE2])
    else $error("bit 16 clear with transmission error");
  chk_pause_done2: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
    (state_reg == ST_DONE && is_pause && !res_next[RB_XPAR]) |=> !result_out[RB_DONE2])
    else $error("pause result would be stored");
  chk_ecc_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R18
    (state_reg == ST_DONE && is_read && ecc_reg && !rpar_reg && !res_next[RB_XPAR]
     && !(acc_reg[22] | acc_reg[23] | drv_reg[15]))
    |=> ({result_out[RB_SF_LO], result_out[RB_SF_LO + 1], result_out[RB_SF_LO + 2]} == SF_ECC
         && !result_out[RB_DONE2]))
    else $error("code-return read flags wrong");
  chk_drv_attn: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R21
    (state_reg == ST_DONE && drv_reg[15] && !rpar_reg && !is_test)
    |=> (result_out[RB_ATTN] && result_out[22] && result_out[23] && result_out[RB_EXC]))
    else $error("drive attention not translated");
endmodule // dpes_top
`default_nettype wire
